// ### logic/dca_pkg.sv
// constants and types for the decoder command arbiter
// Behaviour
// - drive commands to video_decoder as APB requester
// - arbitrate CPU and command_regulator command sources
// - graphics served until its occupancy timer expires
// - CPU served until its occupancy timer expires
// - graphics occupancy zero: drain all graphics first
// - CPU occupancy zero: drain all CPU first
// - nonzero field N means N times 4 clocks
// - normal priority; promotion timer counts while waiting
// - expired promotion makes source high priority, served next; two promoted sources alternate
// - serving a source restarts its promotion timer
// - graphics promotion in bits 7:4, zero disables
// - CPU promotion in bits 3:0, zero disables
// - waiting source is promoted once its promotion interval expires
package dca_pkg;
    localparam logic [7:0] OCC_OFFSET = 8'h88;
    localparam logic [7:0] PROMO_OFFSET = 8'h89;
    localparam logic [7:0] OCC_RESET = 8'h00;
    localparam logic [7:0] PROMO_RESET = 8'h11;
    localparam int CPU_LSB = 0;
    localparam int GFX_LSB = 4;
    localparam int FIELD_W = 4;
    localparam int UNIT_SHIFT = 2;
    localparam int TMR_W = FIELD_W + UNIT_SHIFT;
    localparam logic SRC_CPU = 1'b0;
    localparam logic SRC_GFX = 1'b1;
    typedef enum logic [1:0] {
        DCA_IDLE = 2'b00,
        DCA_SETUP = 2'b01,
        DCA_ACCESS = 2'b11
    } dca_state_t;
endpackage

// ### logic/dca_timer_if.sv
// carrier between the arbiter and one expiry timer
`timescale 1ns/1ps
interface dca_timer_if;
    logic [dca_pkg::FIELD_W-1:0] limit;
    logic run;
    logic clear;
    logic expired;
    modport ctrl (output limit, output run, output clear, input expired);
    modport tmr (input limit, input run, input clear, output expired);
endinterface

// ### logic/dca_timer.sv
// saturating expiry timer, limit in steps of four clocks
`timescale 1ns/1ps
module dca_timer (
    input wire logic clk,
    input wire logic srst,
    dca_timer_if.tmr t
);
    import dca_pkg::*;
    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] span;

    assign span = {t.limit, {UNIT_SHIFT{1'b0}}};

    always_ff @(posedge clk) begin
        if (srst || t.clear) begin
            cnt_r <= '0;
        end else if (t.run && cnt_r < span) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // zero limit never expires, which turns the timer off
    // compare with >= so a lowered limit bites at once instead of never, since the count holds above it
    assign t.expired = (t.limit != '0) && (cnt_r >= span);
endmodule

// ### logic/dca_arbiter.sv
// decoder command arbiter: two command sources onto one APB requester
`timescale 1ns/1ps
module dca_arbiter (
    input wire logic clk,
    input wire logic srst,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    input wire logic cpu_req,
    input wire logic cpu_write,
    input wire logic [31:0] cpu_addr,
    input wire logic [31:0] cpu_wdata,
    output logic cpu_ack,
    input wire logic gfx_req,
    input wire logic gfx_write,
    input wire logic [31:0] gfx_addr,
    input wire logic [31:0] gfx_wdata,
    output logic gfx_ack,
    output logic [31:0] rsp_rdata,
    output logic rsp_err,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import dca_pkg::*;

    dca_state_t state_r;
    logic [7:0] occ_r;
    logic [7:0] promo_r;
    logic cur_src_r;
    logic last_hp_r;
    logic done;
    logic cpu_pend;
    logic gfx_pend;
    logic gnt;
    logic gnt_src;
    logic hp_cpu;
    logic hp_gfx;

    dca_timer_if occ_cpu ();
    dca_timer_if occ_gfx ();
    dca_timer_if pro_cpu ();
    dca_timer_if pro_gfx ();

    dca_timer u_occ_cpu (.clk(clk), .srst(srst), .t(occ_cpu));
    dca_timer u_occ_gfx (.clk(clk), .srst(srst), .t(occ_gfx));
    dca_timer u_pro_cpu (.clk(clk), .srst(srst), .t(pro_cpu));
    dca_timer u_pro_gfx (.clk(clk), .srst(srst), .t(pro_gfx));

    // register file
    always_ff @(posedge clk) begin
        if (srst) begin
            occ_r <= OCC_RESET;
            promo_r <= PROMO_RESET;
        end else if (cfg_wr && cfg_addr == OCC_OFFSET) begin
            occ_r <= cfg_wdata;
        end else if (cfg_wr && cfg_addr == PROMO_OFFSET) begin
            promo_r <= cfg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_rdata <= '0;
        end else begin
            unique case (cfg_addr)
                OCC_OFFSET: cfg_rdata <= occ_r;
                PROMO_OFFSET: cfg_rdata <= promo_r;
                default: cfg_rdata <= '0;
            endcase
        end
    end

    // a source shows its next command only after its ack, so mask it there
    assign cpu_pend = cpu_req && !cpu_ack;
    assign gfx_pend = gfx_req && !gfx_ack;
    assign done = (state_r == DCA_ACCESS) && pready;

    // occupancy: runs while a source holds the grant, restarts on a switch
    assign occ_cpu.limit = occ_r[CPU_LSB +: FIELD_W];
    assign occ_gfx.limit = occ_r[GFX_LSB +: FIELD_W];
    assign occ_cpu.run = (cur_src_r == SRC_CPU);
    assign occ_gfx.run = (cur_src_r == SRC_GFX);
    assign occ_cpu.clear = gnt && gnt_src != cur_src_r;
    assign occ_gfx.clear = gnt && gnt_src != cur_src_r;

    // promotion: counts while waiting, cleared once served
    assign pro_cpu.limit = promo_r[CPU_LSB +: FIELD_W];
    assign pro_gfx.limit = promo_r[GFX_LSB +: FIELD_W];
    assign pro_cpu.run = cpu_pend;
    assign pro_gfx.run = gfx_pend;
    assign pro_cpu.clear = cpu_ack;
    assign pro_gfx.clear = gfx_ack;
    assign hp_cpu = pro_cpu.expired && cpu_pend;
    assign hp_gfx = pro_gfx.expired && gfx_pend;

    // no grant in the ack cycle: the served source's next command is not visible yet,
    // and granting then would hand every turn to the other side and break draining
    assign gnt = (state_r == DCA_IDLE) && !cpu_ack && !gfx_ack && (cpu_pend || gfx_pend);

    always_comb begin
        gnt_src = cur_src_r;
        if (hp_cpu && hp_gfx) begin
            gnt_src = !last_hp_r;
        end else if (hp_cpu) begin
            gnt_src = SRC_CPU;
        end else if (hp_gfx) begin
            gnt_src = SRC_GFX;
        end else if (!cpu_pend) begin
            gnt_src = SRC_GFX;
        end else if (!gfx_pend) begin
            gnt_src = SRC_CPU;
        end else if (cur_src_r == SRC_GFX) begin
            gnt_src = occ_gfx.expired ? SRC_CPU : SRC_GFX;
        end else begin
            gnt_src = occ_cpu.expired ? SRC_GFX : SRC_CPU;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cur_src_r <= SRC_CPU;
        end else if (gnt) begin
            cur_src_r <= gnt_src;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            last_hp_r <= SRC_GFX;
        end else if (gnt && hp_cpu && hp_gfx) begin
            last_hp_r <= gnt_src;
        end
    end

    // apb requester
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= DCA_IDLE;
        end else begin
            unique case (state_r)
                DCA_IDLE: if (gnt) state_r <= DCA_SETUP;
                DCA_SETUP: state_r <= DCA_ACCESS;
                DCA_ACCESS: if (pready) state_r <= DCA_IDLE;
                default: state_r <= DCA_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            psel <= 1'b0;
            penable <= 1'b0;
            pwrite <= 1'b0;
            paddr <= '0;
            pwdata <= '0;
        end else if (gnt) begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= gnt_src ? gfx_write : cpu_write;
            paddr <= gnt_src ? gfx_addr : cpu_addr;
            pwdata <= gnt_src ? gfx_wdata : cpu_wdata;
        end else if (state_r == DCA_SETUP) begin
            penable <= 1'b1;
        end else if (done) begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cpu_ack <= 1'b0;
            gfx_ack <= 1'b0;
            rsp_rdata <= '0;
            rsp_err <= 1'b0;
        end else begin
            cpu_ack <= done && cur_src_r == SRC_CPU;
            gfx_ack <= done && cur_src_r == SRC_GFX;
            if (done) begin
                rsp_rdata <= prdata;
                rsp_err <= pslverr;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence setup_seq;
        psel && !penable;
    endsequence
    sequence access_seq;
        psel && penable;
    endsequence

    chk_apb_phase: assert property (setup_seq |=> access_seq)
        else $error("setup phase not followed by access");
    chk_one_xfer: assert property ((access_seq and !pready) |=> (access_seq and $stable(paddr)))
        else $error("transfer changed before completion");
    chk_ack_after: assert property ((access_seq and pready) |=> (cpu_ack ^ gfx_ack) && !psel)
        else $error("completed transfer not acknowledged once");
    chk_gfx_occ: assert property (gnt && !hp_cpu && !hp_gfx && cpu_pend && gfx_pend && cur_src_r
        && occ_gfx.expired |-> gnt_src == SRC_CPU)
        else $error("graphics kept grant past occupancy");
    chk_cpu_occ: assert property (gnt && !hp_cpu && !hp_gfx && cpu_pend && gfx_pend && !cur_src_r
        && occ_cpu.expired |-> gnt_src == SRC_GFX)
        else $error("cpu kept grant past occupancy");
    chk_gfx_drain: assert property (gnt && !hp_cpu && gfx_pend && cur_src_r
        && occ_r[GFX_LSB +: FIELD_W] == '0 |-> gnt_src == SRC_GFX)
        else $error("graphics left before draining");
    chk_cpu_drain: assert property (gnt && !hp_gfx && cpu_pend && !cur_src_r
        && occ_r[CPU_LSB +: FIELD_W] == '0 |-> gnt_src == SRC_CPU)
        else $error("cpu left before draining");
    chk_promo_win: assert property (gnt && hp_gfx && !hp_cpu |=> paddr == $past(gfx_addr))
        else $error("promoted graphics not served next");
    chk_promo_off: assert property (promo_r[GFX_LSB +: FIELD_W] == '0 |-> !hp_gfx)
        else $error("graphics promoted while disabled");
    chk_promo_rst: assert property (cpu_ack && promo_r[CPU_LSB +: FIELD_W] != '0 |=> !pro_cpu.expired)
        else $error("cpu promotion not restarted");
    chk_both_alt: assert property (gnt && hp_cpu && hp_gfx |-> gnt_src != last_hp_r)
        else $error("promoted sources not alternated");
endmodule

// ### dv/dca_apb_slave.sv
// apb completer model standing in for the decoder modules
`timescale 1ns/1ps
module dca_apb_slave (
    input wire logic clk,
    input wire logic [1:0] waits,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    int cnt = 0;
    // wait states stretch the access phase, so held fields get tested
    always @(posedge clk) cnt <= (psel && penable && !pready) ? cnt + 1 : 0;
    // outside a completing beat the data shows junk, never the last answer
    always_comb begin
        pready = psel && penable && cnt >= int'(waits);
        prdata = pready ? paddr ^ 32'h5a5a_0000 : ~paddr;
        pslverr = pready ? paddr[2] : ~paddr[2];
    end
endmodule

// ### dv/testbench.sv
// self-checking bench for the decoder command arbiter
`timescale 1ns/1ps
module testbench;
    import dca_pkg::*;
    logic clk = 0;
    logic srst = 1;
    logic cfg_wr = 0;
    logic [7:0] cfg_addr = 8'h00;
    logic [7:0] cfg_wdata = 8'h00;
    logic [7:0] cfg_rdata;
    logic [1:0] req = 2'h0, wr = 2'h0, ack, en = 2'h0, waits = 2'h0;
    logic [31:0] a[2] = '{32'h0, 32'h0};
    logic [31:0] d[2] = '{32'h0, 32'h0};
    logic [31:0] q[2][$];
    logic [31:0] qd[2][$];
    logic [31:0] rsp_rdata, paddr, pwdata, prdata, e;
    logic rsp_err, psel, penable, pwrite, pready, pslverr;
    int miscompares = 0, n_tests = 0, seed = 79, cycles = 0, k = 0;
    int last = 0, streak = 0, max_streak = 0, switches = 0, sw_at = 0, wait_gfx = 0, max_wait = 0;
    initial forever #5 clk = ~clk;
    dca_arbiter dca_arbiter_inst (.clk, .srst, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata,
        .cpu_req(req[0]), .cpu_write(wr[0]), .cpu_addr(a[0]), .cpu_wdata(d[0]), .cpu_ack(ack[0]),
        .gfx_req(req[1]), .gfx_write(wr[1]), .gfx_addr(a[1]), .gfx_wdata(d[1]), .gfx_ack(ack[1]),
        .rsp_rdata, .rsp_err, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    dca_apb_slave dca_apb_slave_inst (.clk, .waits, .psel, .penable, .paddr, .prdata, .pready, .pslverr);
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic complete_run;
        $display("tests=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // sources: level request held to ack, next command presented right after
    always @(negedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            complete_run();
        end
        // fields of the transfer in flight must match the command being served
        if (psel === 1'b1 && penable === 1'b1) begin
            k = (q[1].size() > 0 && q[1][0] === paddr) ? 1 : 0;
            chk(paddr, q[k][0]);
            chk(pwdata, qd[k][0]);
            chk({31'h0, pwrite}, {31'h0, q[k][0][3]});
        end
        waits = 2'($random(seed));
        for (int s = 0; s < 2; s++) begin
            if (ack[s] === 1'b1) begin
                e = q[s].pop_front();
                qd[s].delete(0);
                chk(rsp_rdata, e ^ 32'h5a5a_0000);
                chk({31'h0, rsp_err}, {31'h0, e[2]});
                streak = (s == last) ? streak + 1 : 1;
                switches += (s != last);
                last = s;
                max_streak = (streak > max_streak) ? streak : max_streak;
            end
            if (ack[s] === 1'b1 || !req[s]) begin
                req[s] = en[s];
                a[s] = $random(seed);
                d[s] = $random(seed);
                wr[s] = a[s][3];
                if (en[s]) begin
                    q[s].push_back(a[s]);
                    qd[s].push_back(d[s]);
                end
            end
        end
        wait_gfx = (req[1] && ack[1] !== 1'b1) ? wait_gfx + 1 : 0;
        max_wait = (wait_gfx > max_wait) ? wait_gfx : max_wait;
    end
    task automatic wr_reg(input logic [7:0] ad, input logic [7:0] v);
        cfg_addr = ad;
        cfg_wdata = v;
        cfg_wr = 1;
        @(negedge clk);
        cfg_wr = 0;
        @(negedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] ad, input logic [7:0] v);
        cfg_addr = ad;
        repeat (2) @(negedge clk);
        chk({24'h0, cfg_rdata}, {24'h0, v});
    endtask
    // both sources kept busy so every turn is a real contention
    task automatic run(input logic [7:0] occ, input logic [7:0] pro);
        wr_reg(8'h88, occ);
        wr_reg(8'h89, pro);
        rd_reg(8'h88, occ);
        rd_reg(8'h89, pro);
        max_streak = 0;
        max_wait = 0;
        switches = 0;
        en = 2'b11;
        repeat (300) @(negedge clk);
        sw_at = switches;
        en = 2'b00;
        repeat (30) @(negedge clk);
        chk(q[0].size() + q[1].size(), 0);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        srst = 0;
        rd_reg(8'h88, 8'h00);
        rd_reg(8'h89, 8'h11);
        wr_reg(8'h8a, 8'hff);
        rd_reg(8'h8a, 8'h00);
        run(8'h0f, 8'h00);
        chk(sw_at, 1);
        run(8'h00, 8'h00);
        chk(sw_at, 0);
        run(8'h22, 8'h00);
        chk({31'h0, max_streak <= 3}, 1);
        run(8'h00, 8'h11);
        chk({31'h0, max_wait <= 24}, 1);
        chk({31'h0, max_streak <= 3}, 1);
        run(8'h00, 8'h10);
        chk({31'h0, max_wait <= 24}, 1);
        // second reset after the last run: registers must fall back to their reset values
        srst = 1;
        @(negedge clk);
        srst = 0;
        rd_reg(OCC_OFFSET, OCC_RESET);
        rd_reg(PROMO_OFFSET, PROMO_RESET);
        complete_run();
    end
endmodule
